// ==== verilog/burst_supply_pkg.sv ====
// Constants, field layouts and carrier types for the burst I/O fault
// monitor and driver supply control block.
// Assumes a 200 MHz clock and a simple byte-wide register port.
//
// How it works
// - Modes 0 and 1: fault if input b idles past the deglitch time.
// - Mode 2: fault if both inputs idle too long, unless both high.
// - Deglitch code 0..6 picks 64..4 us; code 7 turns the check off.
// - Two-bit I/O mode field at bits 1:0, reset to mode 0.
// - Auto-off set and trigger clear: charging stops after each burst.
// - Float bit, reset 1, turns off supply current and regulation.
// - Bit 4 picks 10 mA or 20 mA pull-up current.
// - Low nibble sets regulated supply as value plus five volts.
// - Supply register at 0x16, reset 0x20, bit 7 reads zero.
// - Trigger bit gates charging under auto-off; ignored while floating.
// - Command trigger starts bursts only in I/O mode 0.
package burst_supply_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] burst_io_addr        = 8'h14;
  localparam logic [7:0] drive_supply_addr    = 8'h16;
  localparam logic [7:0] burst_cmd_addr       = 8'h1b;
  localparam logic [7:0] status_addr          = 8'h1c;
  localparam logic [7:0] burst_io_reset       = 8'h00;
  localparam logic [7:0] drive_supply_reset   = 8'h20;
  localparam logic [7:0] burst_cmd_reset      = 8'h00;
  localparam logic [7:0] drive_supply_wmask   = 8'h7f;
  localparam logic [7:0] burst_io_wmask       = 8'hff;
  localparam logic [7:0] burst_cmd_wmask      = 8'h03;
  localparam int         status_fault_bit     = 0;

  // ****************************************************************
  // Field codes
  // ****************************************************************
  localparam logic [2:0] deglitch_off_code    = 3'h7;
  localparam int         volt_offset_v        = 5;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int clk_mhz                      = 200;
  localparam int deglitch_64_us               = 64;
  localparam int deglitch_48_us               = 48;
  localparam int deglitch_32_us               = 32;
  localparam int deglitch_24_us               = 24;
  localparam int deglitch_16_us               = 16;
  localparam int deglitch_8_us                = 8;
  localparam int deglitch_4_us                = 4;
  localparam int cnt_w                        = 14;

  typedef enum logic [1:0] {
    io_mode_0 = 2'b00,
    io_mode_1 = 2'b01,
    io_mode_2 = 2'b10,
    io_mode_3 = 2'b11
  } io_mode_t;

  typedef struct packed {
    logic       reserved;
    logic [1:0] reserved_b;
    logic [2:0] pulse_fault_deglitch_sel;
    io_mode_t   io_mode;
  } burst_io_t;

  typedef struct packed {
    logic       reserved;
    logic       auto_charge_off_listen;
    logic       drive_supply_float;
    logic       drive_supply_pullup_sel;
    logic [3:0] drive_supply_volt_sel;
  } drive_supply_t;

  typedef struct packed {
    logic       current_enable;
    logic       current_20ma;
    logic       regulation_on;
    logic [4:0] volts;
  } supply_ctrl_t;

endpackage : burst_supply_pkg

// ==== verilog/burst_io_fault_and_supply_ctrl.sv ====
// Register bank, burst pulse fault monitor and driver supply control.
// Assumes the register port is synchronous to clk, inputs synchronous.
`timescale 1ns/1ps
`default_nettype none

module burst_io_fault_and_supply_ctrl (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  // Register port
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  input  wire logic [7:0]                      reg_addr,
  input  wire logic [7:0]                      reg_wdata,
  output var  logic [7:0]                      reg_rdata,
  // Burst inputs
  input  wire logic                            burst_input_a,
  input  wire logic                            burst_input_b,
  // Status and supply control
  output var  logic                            burst_active,
  output var  logic                            drive_pulse_fault_flag,
  output var  burst_supply_pkg::supply_ctrl_t  supply_ctrl
);

  // ****************************************************************
  // Timeout table
  // ****************************************************************
  function automatic logic [13:0] timeout_cycles(input logic [2:0] sel);
    int us;
    us = burst_supply_pkg::deglitch_64_us;
    unique case (sel)
      3'h0: us = burst_supply_pkg::deglitch_64_us;
      3'h1: us = burst_supply_pkg::deglitch_48_us;
      3'h2: us = burst_supply_pkg::deglitch_32_us;
      3'h3: us = burst_supply_pkg::deglitch_24_us;
      3'h4: us = burst_supply_pkg::deglitch_16_us;
      3'h5: us = burst_supply_pkg::deglitch_8_us;
      3'h6: us = burst_supply_pkg::deglitch_4_us;
      3'h7: us = burst_supply_pkg::deglitch_4_us;
    endcase
    return 14'(us * burst_supply_pkg::clk_mhz);
  endfunction : timeout_cycles

  // ****************************************************************
  // Registers
  // ****************************************************************
  burst_supply_pkg::burst_io_t     burst_io_reg;
  burst_supply_pkg::drive_supply_t drive_supply_reg;
  logic                            cmd_trigger_reg;
  logic                            charge_trigger_reg;
  logic                            fault_reg;
  logic [13:0]                     cnt_reg;
  logic                            a_q_reg;
  logic                            b_q_reg;
  logic                            burst_reg;
  logic                            charge_off_reg;

  wire wr_io     = reg_wr && reg_addr == burst_supply_pkg::burst_io_addr;
  wire wr_supply = reg_wr && reg_addr == burst_supply_pkg::drive_supply_addr;
  wire wr_cmd    = reg_wr && reg_addr == burst_supply_pkg::burst_cmd_addr;
  wire wr_stat   = reg_wr && reg_addr == burst_supply_pkg::status_addr;
  wire clr_fault = wr_stat &&
                   reg_wdata[burst_supply_pkg::status_fault_bit];

  wire [7:0] supply_wr_val = reg_wdata &
                             burst_supply_pkg::drive_supply_wmask;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      burst_io_reg       <= burst_supply_pkg::burst_io_reset;
      drive_supply_reg   <= burst_supply_pkg::drive_supply_reset;
      cmd_trigger_reg    <= burst_supply_pkg::burst_cmd_reset[0];
      charge_trigger_reg <= burst_supply_pkg::burst_cmd_reset[1];
    end else begin
      if (wr_io)
        burst_io_reg <= reg_wdata & burst_supply_pkg::burst_io_wmask;
      if (wr_supply)
        drive_supply_reg <= supply_wr_val;
      if (wr_cmd) begin
        cmd_trigger_reg    <= reg_wdata[0];
        charge_trigger_reg <= reg_wdata[1];
      end
    end
  end

  // ****************************************************************
  // Burst detection
  // ****************************************************************
  burst_supply_pkg::io_mode_t mode;
  assign mode = burst_io_reg.io_mode;

  wire edge_a = burst_input_a ^ a_q_reg;
  wire edge_b = burst_input_b ^ b_q_reg;
  wire mode_cmd = mode == burst_supply_pkg::io_mode_0;
  wire mode_2   = mode == burst_supply_pkg::io_mode_2;
  wire mode_01  = mode == burst_supply_pkg::io_mode_0 ||
                  mode == burst_supply_pkg::io_mode_1;

  // Mode 0 follows the command bit; other modes start on pin activity
  wire burst_next = mode_cmd ? cmd_trigger_reg
                  : (mode_2 ? (burst_input_a | burst_input_b)
                            : burst_input_a);
  wire burst_end  = burst_reg && !burst_next;

  // ****************************************************************
  // Pulse fault monitor
  // ****************************************************************
  wire check_on  = burst_io_reg.pulse_fault_deglitch_sel !=
                   burst_supply_pkg::deglitch_off_code;
  wire both_high = burst_input_a && burst_input_b;
  wire qual_edge = mode_2 ? (edge_a || edge_b) : edge_b;
  wire watching  = burst_reg && check_on && (mode_01 || mode_2) &&
                   !(mode_2 && both_high);
  wire [13:0] limit = timeout_cycles(burst_io_reg.pulse_fault_deglitch_sel);
  wire timeout   = watching && cnt_reg >= limit;

  wire [13:0] cnt_next = (!watching || qual_edge) ? 14'h0000
                       : (timeout ? cnt_reg : cnt_reg + 14'h0001);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      a_q_reg   <= 1'b0;
      b_q_reg   <= 1'b0;
      burst_reg <= 1'b0;
      cnt_reg   <= 14'h0000;
      fault_reg <= 1'b0;
    end else begin
      a_q_reg   <= burst_input_a;
      b_q_reg   <= burst_input_b;
      burst_reg <= burst_next;
      cnt_reg   <= cnt_next;
      // Set beats a clear in the same cycle
      fault_reg <= timeout | (fault_reg & ~clr_fault);
    end
  end

  // ****************************************************************
  // Driver supply control
  // ****************************************************************
  wire auto_off = drive_supply_reg.auto_charge_off_listen;
  wire floating = drive_supply_reg.drive_supply_float;

  // Charging latched off at each burst end when auto-off and no trigger
  wire charge_off_next = !auto_off || charge_trigger_reg || burst_next
                         ? 1'b0
                         : (burst_end ? 1'b1 : charge_off_reg);

  burst_supply_pkg::supply_ctrl_t supply_next;
  assign supply_next.current_enable = !floating &&
                                      !charge_off_next;
  assign supply_next.current_20ma   = drive_supply_reg.drive_supply_pullup_sel;
  assign supply_next.regulation_on  = !floating;
  assign supply_next.volts = 5'(drive_supply_reg.drive_supply_volt_sel) +
                             5'(burst_supply_pkg::volt_offset_v);

  // ****************************************************************
  // Read mux
  // ****************************************************************
  logic [7:0] rdata_next;
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      burst_supply_pkg::burst_io_addr:     rdata_next = burst_io_reg;
      burst_supply_pkg::drive_supply_addr: rdata_next = drive_supply_reg;
      burst_supply_pkg::burst_cmd_addr:
        rdata_next = {6'h00, charge_trigger_reg, cmd_trigger_reg};
      burst_supply_pkg::status_addr:       rdata_next = {7'h00, fault_reg};
      default:                             rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      charge_off_reg         <= 1'b0;
      supply_ctrl            <= '0;
      reg_rdata              <= 8'h00;
      burst_active           <= 1'b0;
      drive_pulse_fault_flag <= 1'b0;
    end else begin
      charge_off_reg         <= charge_off_next;
      supply_ctrl            <= supply_next;
      reg_rdata              <= reg_rd ? rdata_next : reg_rdata;
      burst_active           <= burst_next;
      drive_pulse_fault_flag <= timeout | (fault_reg & ~clr_fault);
    end
  end

endmodule : burst_io_fault_and_supply_ctrl

`default_nettype wire

// ==== verif/burst_pin_driver.sv ====
// Controller-side model that works the two burst pins.
// Assumes the bench selects the pin pattern between clock edges.
`timescale 1ns/1ps
`default_nettype none
module burst_pin_driver (
  // Clock and pattern select
  input  wire logic       clk,
  input  wire logic [1:0] pattern,
  // Burst pins
  output var  logic       burst_input_a,
  output var  logic       burst_input_b
);
  logic [3:0] div_reg;
  initial begin
    div_reg = 4'h0;
    burst_input_a = 1'b0;
    burst_input_b = 1'b0;
  end
  // 0 idle low, 1 toggle every 16 cycles, 2 both high, 3 stalled
  always @(posedge clk) begin
    div_reg <= div_reg + 4'h1;
    case (pattern)
      2'h1: if (div_reg == 4'hf) begin
        burst_input_a <= ~burst_input_a;
        burst_input_b <= ~burst_input_b;
      end
      2'h2: {burst_input_a, burst_input_b} <= 2'b11;
      2'h3: {burst_input_a, burst_input_b} <= 2'b10;
      default: {burst_input_a, burst_input_b} <= 2'b00;
    endcase
  end
endmodule : burst_pin_driver
`default_nettype wire

// ==== verif/burst_supply_assertions.sv ====
// Assertion checker for the burst fault and supply block.
// Sees only the top-level ports; bound in at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module burst_supply_checker (
  // Clock, reset and register port
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Pins and status
  input wire logic       burst_input_a,
  input wire logic       burst_input_b,
  input wire logic       burst_active,
  input wire logic       drive_pulse_fault_flag,
  input wire burst_supply_pkg::supply_ctrl_t supply_ctrl
);
  // ****
  // Shadow of the I/O register and idle time of input b
  // ****
  localparam int lim_us [8] = '{64, 48, 32, 24, 16, 8, 4, 0};
  logic [7:0]  io_reg;
  logic [15:0] idle_reg;
  logic        b_reg;
  int          lim;
  always_comb lim = 200 * lim_us[io_reg[4:2]];
  always_ff @(posedge clk) begin
    if (!rst_b) io_reg <= 8'h00;
    else if (reg_wr && reg_addr == 8'h14) io_reg <= reg_wdata;
    if (!burst_active || burst_input_b != b_reg) idle_reg <= 16'h0;
    else if (idle_reg != 16'hffff) idle_reg <= idle_reg + 16'h1;
    b_reg <= burst_input_b;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence sup_wr;
    reg_wr && reg_addr == 8'h16 ##1 !reg_wr;
  endsequence
  chk_fault_sticky: assert property ($fell(drive_pulse_fault_flag)
    |-> $past(reg_wr && reg_addr == 8'h1c && reg_wdata[0]))
    else $error("fault flag dropped without a clear");
  chk_volt_sel: assert property (sup_wr |=>
    supply_ctrl.volts == {1'b0, $past(reg_wdata[3:0], 2)} + 5'h5)
    else $error("supply voltage code wrong");
  chk_float_off: assert property (reg_wr && reg_addr == 8'h16
    && reg_wdata[5] ##1 !reg_wr |=>
    !supply_ctrl.current_enable && !supply_ctrl.regulation_on)
    else $error("floating supply still driven");
  chk_pullup_sel: assert property (reg_wr && reg_addr == 8'h16
    && !reg_wdata[5] ##1 !reg_wr
    |=> supply_ctrl.current_20ma == $past(reg_wdata[4], 2)
    && supply_ctrl.regulation_on)
    else $error("pull-up current select wrong");
  chk_rsv_zero: assert property (reg_rd && reg_addr == 8'h16
    |=> !reg_rdata[7]) else $error("reserved bit reads one");
  chk_no_early: assert property ($rose(drive_pulse_fault_flag)
    && !io_reg[1] |-> idle_reg >= lim)
    else $error("fault raised before deglitch time");
  chk_no_late: assert property (burst_active && !io_reg[1]
    && io_reg[4:2] != 3'h7 && idle_reg == lim + 8
    |-> drive_pulse_fault_flag) else $error("fault not raised in time");
  chk_check_off: assert property (io_reg[4:2] == 3'h7
    || io_reg[1:0] == 2'h3 |-> !$rose(drive_pulse_fault_flag))
    else $error("fault raised while check is off");
  chk_cmd_start: assert property (reg_wr && reg_addr == 8'h1b
    && reg_wdata[0] && io_reg[1:0] == 2'h0 |-> ##[1:3] burst_active)
    else $error("burst did not start on command");
  cov_fault: cover property ($rose(drive_pulse_fault_flag));
  cov_burst_end: cover property ($fell(burst_active));
  cov_supply_rd: cover property (reg_rd && reg_addr == 8'h16);
endmodule : burst_supply_checker
bind burst_io_fault_and_supply_ctrl burst_supply_checker i_checker (
  .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .burst_input_a(burst_input_a), .burst_input_b(burst_input_b),
  .burst_active(burst_active),
  .drive_pulse_fault_flag(drive_pulse_fault_flag),
  .supply_ctrl(supply_ctrl));
`default_nettype wire

// ==== verif/burst_io_fault_and_supply_ctrl_test.sv ====
// Self-checking bench for the burst fault and supply block.
// The pin driver model works the burst pins; tasks drive the registers.
`timescale 1ns/1ps
`default_nettype none
module burst_io_fault_and_supply_ctrl_test;
  logic       clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0] pattern = 2'h0;
  logic       burst_input_a, burst_input_b, burst_active, fault;
  int         failures = 0, samples_checked = 0;
  burst_supply_pkg::supply_ctrl_t supply_ctrl;
  initial forever #2.5 clk = ~clk;
  burst_io_fault_and_supply_ctrl i_burst_io_fault_and_supply_ctrl (
    .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .burst_input_a(burst_input_a), .burst_input_b(burst_input_b),
    .burst_active(burst_active), .drive_pulse_fault_flag(fault),
    .supply_ctrl(supply_ctrl));
  burst_pin_driver i_burst_pin_driver (.clk(clk), .pattern(pattern),
    .burst_input_a(burst_input_a), .burst_input_b(burst_input_b));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    tick(1);
    reg_wr = 1'b0;
    tick(2);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    {reg_rd, reg_addr} = {1'b1, a};
    tick(1);
    reg_rd = 1'b0;
    tick(1);
    check(reg_rdata, exp);
  endtask : rd
  task automatic s_supply;
    rd(8'h16, 8'h20);
    rd(8'h14, 8'h00);
    check(supply_ctrl, 8'h05);
    wr(8'h16, 8'hff);
    rd(8'h16, 8'h7f);
    check(supply_ctrl, 8'h54);
    wr(8'h16, 8'h1a);
    check(supply_ctrl, 8'hef);
    wr(8'h16, 8'h00);
    check(supply_ctrl, 8'ha5);
    rd(8'h00, 8'h00);
  endtask : s_supply
  task automatic s_fault;
    int us [8];
    int lim;
    us = '{64, 48, 32, 24, 16, 8, 4, 0};
    for (int c = 0; c < 8; c++) begin
      lim = (c == 7) ? 2000 : 200 * us[c];
      wr(8'h14, {3'h0, 3'(c), 1'b0, 1'(c)});
      pattern = 2'h1;
      wr(8'h1b, 8'h01);
      tick(lim + 400);
      check(8'(fault), 8'h00);
      // Raise b first so the stall starts at a known edge
      pattern = 2'h2;
      tick(2);
      pattern = 2'h3;
      tick(lim - 10);
      check(8'(fault), 8'h00);
      tick(20);
      check(8'(fault), 8'(c != 7));
      wr(8'h1b, 8'h00);
      pattern = 2'h0;
      tick(5);
      wr(8'h1c, 8'h01);
      check(8'(fault), 8'h00);
    end
  endtask : s_fault
  task automatic s_modes;
    wr(8'h14, 8'h19);
    wr(8'h1b, 8'h01);
    check(8'(burst_active), 8'h00);
    wr(8'h1b, 8'h00);
    wr(8'h14, 8'h1a);
    pattern = 2'h2;
    tick(1600);
    check(8'(fault), 8'h00);
    pattern = 2'h3;
    tick(850);
    check(8'(fault), 8'h01);
    rd(8'h1c, 8'h01);
    pattern = 2'h0;
    tick(5);
    wr(8'h1c, 8'h01);
    wr(8'h14, 8'h1b);
    pattern = 2'h3;
    tick(1600);
    check(8'(fault), 8'h00);
    pattern = 2'h0;
  endtask : s_modes
  task automatic s_charge;
    wr(8'h14, 8'h18);
    wr(8'h16, 8'h45);
    pattern = 2'h1;
    wr(8'h1b, 8'h01);
    tick(100);
    check(8'(supply_ctrl.current_enable), 8'h01);
    wr(8'h1b, 8'h00);
    pattern = 2'h0;
    tick(5);
    check(8'(supply_ctrl.current_enable), 8'h00);
    wr(8'h1b, 8'h02);
    check(8'(supply_ctrl.current_enable), 8'h01);
    wr(8'h16, 8'h65);
    check(8'(supply_ctrl.current_enable), 8'h00);
  endtask : s_charge
  task automatic give_verdict;
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    tick(3);
    rst_b = 1'b1;
    s_supply;
    s_fault;
    s_modes;
    s_charge;
    give_verdict;
  end
  initial begin
    #700us;
    failures++;
    give_verdict;
  end
endmodule : burst_io_fault_and_supply_ctrl_test
`default_nettype wire
